/* shared/bscc_regs.vh */
// constants for the backlight sink-current control block
// assumes inclusion by the design files of this block only
`ifndef BSCC_REGS_VH
`define BSCC_REGS_VH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define BSCC_ADDR_SINK      16'ha086
`define BSCC_ADDR_CLKCTL    16'ha087

// ----------------------------------------
// sink_current_setting fields
// ----------------------------------------
`define BSCC_CODE_MSB       4
`define BSCC_CODE_LSB       0
`define BSCC_RSVD5_BIT      5
`define BSCC_RANGE_BIT      6
`define BSCC_LOCAL_ON_BIT   7
`define BSCC_SINK_RESET     8'h40

// ----------------------------------------
// boost_clock_control fields
// ----------------------------------------
`define BSCC_FREQ_BIT       1
`define BSCC_CLKCTL_RESET   8'h02
`define BSCC_CLKCTL_WMASK   8'hcf

// ----------------------------------------
// timing
// ----------------------------------------
`define BSCC_CLK_HZ         20000000
`define BSCC_SLEW_STEP_US   32
`define BSCC_SLEW_CYCLES    ((`BSCC_CLK_HZ / 1000000) * `BSCC_SLEW_STEP_US)
`define BSCC_SS_CYCLES      1000

`endif

/* hw/bscc_slew.v */
// slew ramp of the sink-current level, one code step per tick
// assumes step_tick is a one-cycle pulse on the same clock
`include "bscc_regs.vh"

module bscc_slew #(
    parameter W = 6
) (
    input  wire         clock,
    input  wire         srst,
    input  wire         run,
    input  wire [W-1:0] target,
    input  wire         step_tick,
    output reg  [W-1:0] level_q,
    output wire         busy
);
    reg [W-1:0] goal_q;
    reg         active_q;

    assign busy = active_q;

    always @(posedge clock) begin
        if (srst) begin
            level_q  <= {W{1'b0}};
            goal_q   <= {W{1'b0}};
            active_q <= 1'b0;
        end else if (!run) begin
            // off: sinks at zero, next ramp starts from zero
            level_q  <= {W{1'b0}};
            goal_q   <= {W{1'b0}};
            active_q <= 1'b0;
        end else if (!active_q) begin
            // new level latched only while idle
            if (target != level_q) begin
                goal_q   <= target;
                active_q <= 1'b1;
            end
        end else if (step_tick) begin
            // one step per tick toward the goal
            if (level_q < goal_q)
                level_q <= level_q + 1'b1;
            else if (level_q > goal_q)
                level_q <= level_q - 1'b1;
            if ((level_q + 1'b1 == goal_q) || (level_q - 1'b1 == goal_q) || (level_q == goal_q))
                active_q <= 1'b0;
        end
    end
endmodule

/* hw/bscc_top.v */
// register bank and enable logic for the two-string backlight boost converter
// assumes one 20 MHz clock; register port shared by i2c slave and local cpu,
// already on this clock; global enable and ovp comparator come from pins
`include "bscc_regs.vh"

module bscc_top #(
    parameter SLEW_CYCLES = `BSCC_SLEW_CYCLES,
    parameter SS_CYCLES   = `BSCC_SS_CYCLES
) (
    input  wire        clock,
    input  wire        srst,
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [15:0] reg_addr,
    input  wire [7:0]  reg_wdata,
    output reg  [7:0]  reg_rdata,
    input  wire        global_enable,
    input  wire        overvoltage_sense_input,
    output wire        converter_run,
    output reg         soft_start_q,
    output reg         loop_reset_q,
    output wire        switching_freq_select,
    output wire        current_range_select,
    output wire [5:0]  sink_steps,
    output wire        slew_busy
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // one decode shared by write and read paths, so both always agree
    function hit_sink;
        input [15:0] addr;
        begin
            hit_sink = (addr == `BSCC_ADDR_SINK);
        end
    endfunction

    function hit_clkctl;
        input [15:0] addr;
        begin
            hit_clkctl = (addr == `BSCC_ADDR_CLKCTL);
        end
    endfunction

    // true on the final cycle of a window of len cycles
    function at_last;
        input [15:0] cnt;
        input [15:0] len;
        begin
            at_last = (cnt == len - 16'h0001);
        end
    endfunction

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    reg gen_s1_q, gen_s2_q, ovp_s1_q, ovp_s2_q;

    always @(posedge clock) begin
        if (srst) begin
            gen_s1_q <= 1'b0;
            gen_s2_q <= 1'b0;
            ovp_s1_q <= 1'b0;
            ovp_s2_q <= 1'b0;
        end else begin
            gen_s1_q <= global_enable;
            gen_s2_q <= gen_s1_q;
            ovp_s1_q <= overvoltage_sense_input;
            ovp_s2_q <= ovp_s1_q;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg [7:0] sink_q;
    reg [7:0] clkctl_q;
    reg [7:0] sink_d;
    reg [7:0] clkctl_d;

    // writes accepted at any time, running or not
    always @* begin
        sink_d   = sink_q;
        clkctl_d = clkctl_q;
        if (reg_wr && hit_sink(reg_addr))
            sink_d = reg_wdata;
        if (reg_wr && hit_clkctl(reg_addr))
            clkctl_d = reg_wdata & `BSCC_CLKCTL_WMASK;
    end

    always @(posedge clock) begin
        if (srst) begin
            // defaults only on reset
            sink_q   <= `BSCC_SINK_RESET;
            clkctl_q <= `BSCC_CLKCTL_RESET;
        end else begin
            sink_q   <= sink_d;
            clkctl_q <= clkctl_d;
        end
    end

    // ----------------------------------------
    // read back
    // ----------------------------------------
    // unmapped reads give zero; read data holds until the next read
    reg [7:0] rdata_d;

    always @* begin
        rdata_d = reg_rdata;
        if (reg_rd) begin
            if (hit_sink(reg_addr))
                rdata_d = sink_q;
            else if (hit_clkctl(reg_addr))
                rdata_d = clkctl_q;
            else
                rdata_d = 8'h00;
        end
    end

    always @(posedge clock) begin
        if (srst)
            reg_rdata <= 8'h00;
        else
            reg_rdata <= rdata_d;
    end

    assign switching_freq_select = clkctl_q[`BSCC_FREQ_BIT];
    assign current_range_select  = sink_q[`BSCC_RANGE_BIT];

    // ----------------------------------------
    // enable and soft start
    // ----------------------------------------
    // local enable resets low, so global alone keeps it off
    assign converter_run = gen_s2_q & sink_q[`BSCC_LOCAL_ON_BIT];

    reg        run_d1_q;
    reg [15:0] ss_cnt_q;
    reg [15:0] ss_cnt_d;
    reg        soft_start_d;

    always @* begin
        soft_start_d = soft_start_q;
        ss_cnt_d     = ss_cnt_q;
        if (!converter_run) begin
            soft_start_d = 1'b0;
            ss_cnt_d     = 16'h0000;
        end else if (ovp_s2_q || !run_d1_q) begin
            // start or restart soft start; ovp hiccups while it lasts
            soft_start_d = 1'b1;
            ss_cnt_d     = 16'h0000;
        end else if (soft_start_q) begin
            if (at_last(ss_cnt_q, SS_CYCLES[15:0]))
                soft_start_d = 1'b0;
            else
                ss_cnt_d = ss_cnt_q + 16'h0001;
        end
    end

    always @(posedge clock) begin
        if (srst) begin
            run_d1_q     <= 1'b0;
            soft_start_q <= 1'b0;
            loop_reset_q <= 1'b0;
            ss_cnt_q     <= 16'h0000;
        end else begin
            run_d1_q     <= converter_run;
            // loop held in reset for each cycle the trip lasts
            loop_reset_q <= converter_run & ovp_s2_q;
            soft_start_q <= soft_start_d;
            ss_cnt_q     <= ss_cnt_d;
        end
    end

    // ----------------------------------------
    // slew timing and ramp
    // ----------------------------------------
    reg [15:0] tick_cnt_q;
    // counter free-runs while on, so a ramp's first step may come early
    wire       step_tick = at_last(tick_cnt_q, SLEW_CYCLES[15:0]);

    always @(posedge clock) begin
        if (srst || !converter_run || step_tick)
            tick_cnt_q <= 16'h0000;
        else
            tick_cnt_q <= tick_cnt_q + 16'h0001;
    end

    // steps = code + 1, zero means sinks off
    wire [5:0] target_steps = {1'b0, sink_q[`BSCC_CODE_MSB:`BSCC_CODE_LSB]} + 6'h01;

    bscc_slew #(
        .W (6)
    ) u_slew (
        .clock     (clock),
        .srst      (srst),
        .run       (converter_run),
        .target    (target_steps),
        .step_tick (step_tick),
        .level_q   (sink_steps),
        .busy      (slew_busy)
    );
endmodule

/* verification/bscc_assertions.sv */
// port assertions for bscc_top
// assumes the bench sets SLEW_CYCLES to 4
module bscc_chk (
    input wire        clock,
    input wire        srst,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire        converter_run,
    input wire        switching_freq_select,
    input wire        current_range_select,
    input wire [15:0] reg_addr,
    input wire [7:0]  reg_wdata,
    input wire [7:0]  reg_rdata,
    input wire [5:0]  sink_steps
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    property p_rst;
        disable iff (1'b0) srst |=> sink_steps == 6'h00 && switching_freq_select && current_range_select;
    endproperty
    a_rst: assert property (p_rst) else $error("reset values");
    property p_off;
        !converter_run ##1 !converter_run |-> sink_steps == 6'h00;
    endproperty
    a_off: assert property (p_off) else $error("sink not zero");
    property p_rng;
        reg_wr && reg_addr == 16'ha086 |=> current_range_select == $past(reg_wdata[6]);
    endproperty
    a_rng: assert property (p_rng) else $error("range");
    property p_frq;
        reg_wr && reg_addr == 16'ha087 |=> switching_freq_select == $past(reg_wdata[1]);
    endproperty
    a_frq: assert property (p_frq) else $error("freq");
    property p_rsv;
        reg_rd && reg_addr == 16'ha087 |=> reg_rdata[5:4] == 2'b00;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved");
    property p_loc;
        reg_wr && reg_addr == 16'ha086 && !reg_wdata[7] |=> !converter_run;
    endproperty
    a_loc: assert property (p_loc) else $error("local off");
    property p_stp;
        converter_run && $changed(sink_steps) |->
            sink_steps == $past(sink_steps) + 6'h01 || sink_steps + 6'h01 == $past(sink_steps);
    endproperty
    a_stp: assert property (p_stp) else $error("step size");
    // three quiet cycles between steps at SLEW_CYCLES of 4
    property p_gap;
        converter_run && $changed(sink_steps) |=> ($stable(sink_steps) || !converter_run) [*3];
    endproperty
    a_gap: assert property (p_gap) else $error("step gap");
endmodule

/* verification/bscc_host.sv */
// host model: one-cycle strobes launched at the falling edge
// assumes the device samples on the rising edge
module bscc_host (
    input  wire         clock,
    input  wire  [7:0]  reg_rdata,
    output logic        reg_wr = 1'b0,
    output logic        reg_rd = 1'b0,
    output logic [15:0] reg_addr = 16'h0000,
    output logic [7:0]  reg_wdata = 8'h00
);
    timeunit 1ns;
    timeprecision 1ns;
    // whole byte always written; released bus shows the inverse
    task automatic wr(input [15:0] a, input [7:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clock);
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask
    task automatic rd(input [15:0] a, output [7:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clock);
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask
endmodule

/* verification/bscc_top_test.sv */
// self-checking bench for bscc_top
// assumes bscc_host owns the register strobes
module bscc_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0, srst = 1'b1, global_enable = 1'b0, overvoltage_sense_input = 1'b0;
    wire reg_wr, reg_rd, converter_run, soft_start_q, loop_reset_q;
    wire switching_freq_select, current_range_select, slew_busy;
    wire [15:0] reg_addr;
    wire [7:0] reg_wdata, reg_rdata;
    wire [5:0] sink_steps;
    logic [7:0] rv;
    int bad_count = 0, checks_done = 0;
    bscc_top #(.SLEW_CYCLES(4), .SS_CYCLES(5)) DUT (.clock, .srst, .reg_wr, .reg_rd, .reg_addr,
        .reg_wdata, .reg_rdata, .global_enable, .overvoltage_sense_input, .converter_run, .soft_start_q,
        .loop_reset_q, .switching_freq_select, .current_range_select, .sink_steps, .slew_busy);
    bscc_host h (.clock, .reg_rdata, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
    initial forever #25 clock = ~clock;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk({7'h00, got}, {7'h00, exp});
    endtask
    task automatic stop_test;
        if (bad_count == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clock);
    endtask
    // a ramp can restart right after the last one, so callers settle twice
    task automatic settle;
        int i;
        idle(3);
        for (i = 0; i < 300 && slew_busy !== 1'b0; i++)
            @(negedge clock);
        if (i == 300) begin
            bad_count++;
            stop_test;
        end
    endtask
    initial begin
        idle(3);
        srst = 1'b0;
        h.rd(16'ha086, rv);
        chk(rv, 8'h40);
        h.rd(16'ha087, rv);
        chk(rv, 8'h02);
        h.rd(16'ha088, rv);
        chk(rv, 8'h00);
        h.wr(16'ha087, 8'hff);
        h.rd(16'ha087, rv);
        chk(rv, 8'hcf);
        h.wr(16'ha087, 8'h00);
        chk1(switching_freq_select, 1'b0);
        global_enable = 1'b1;
        idle(4);
        chk1(converter_run, 1'b0);
        h.wr(16'ha086, 8'h83);
        chk1(converter_run, 1'b1);
        idle(1);
        chk1(soft_start_q, 1'b1);
        settle;
        chk({2'b00, sink_steps}, 8'h04);
        chk1(current_range_select, 1'b0);
        h.wr(16'ha086, 8'hc1);
        h.wr(16'ha086, 8'hc7);
        settle;
        chk({2'b00, sink_steps}, 8'h02);
        settle;
        chk({2'b00, sink_steps}, 8'h08);
        overvoltage_sense_input = 1'b1;
        idle(4);
        chk1(loop_reset_q, 1'b1);
        chk1(soft_start_q, 1'b1);
        overvoltage_sense_input = 1'b0;
        h.wr(16'ha086, 8'h47);
        chk1(converter_run, 1'b0);
        idle(2);
        chk({2'b00, sink_steps}, 8'h00);
        global_enable = 1'b0;
        idle(4);
        h.wr(16'ha086, 8'hc7);
        chk1(converter_run, 1'b0);
        chk({2'b00, sink_steps}, 8'h00);
        h.rd(16'ha086, rv);
        chk(rv, 8'hc7);
        srst = 1'b1;
        idle(1);
        srst = 1'b0;
        h.rd(16'ha086, rv);
        chk(rv, 8'h40);
        stop_test;
    end
endmodule
bind bscc_top bscc_chk u_chk (
    .clock                 (clock),
    .srst                  (srst),
    .reg_wr                (reg_wr),
    .reg_rd                (reg_rd),
    .converter_run         (converter_run),
    .switching_freq_select (switching_freq_select),
    .current_range_select  (current_range_select),
    .reg_addr              (reg_addr),
    .reg_wdata             (reg_wdata),
    .reg_rdata             (reg_rdata),
    .sink_steps            (sink_steps)
);
